// File: design/usbdm_pkg.sv
// Contract
// RULE1: Mode bit 7 selects 16-bit DMA path.
// RULE2: Writing 1 then 0 to bit 5 suspends.
// RULE3: Mode bit 3 gates all interrupts out.
// RULE4: Mode bit 2 interrupts on NAKs and errors.
// RULE5: Otherwise interrupt on bulk ACK, iso transfer.
// RULE6: Soft attach ignored when external pull-up selected.
// RULE7: Bus reset keeps mode bits 7,3,2,0.
// RULE8: Bus reset never alters hardware configuration.
// RULE9: Command BA writes, BB reads, one word.
// RULE10: Hardware configuration is two bytes wide.
// RULE11: Config bit 14 means external D+ pull-up.
// RULE12: Config bit 13 stops slow clock output.
// RULE13: Else output slow clock 2 ms after trigger.
// RULE14: Config bit 12 keeps internal clocks running.
// RULE15: Else oscillator stops 2 ms after trigger.
// RULE16: Firmware clears bit 12 before suspend.
// RULE17: Divider N gives output 48/(N+1) MHz; code divides ref_clk by 2(N+1).
// RULE18: Divider resets to 3, giving 12 MHz; code gives 2.5 MHz from the 20 MHz ref_clk.
// RULE19: Divider changes without glitch or runt pulse.
// RULE20: Config bit 1 selects level or pulse.
// RULE21: Config bit 7 selects acknowledge-only DMA.
// RULE22: Config bit 2 drives power switch in suspend.
// RULE23: Firmware writes reserved bits as zero.
package usbdm_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_MODE_WR = 8'hB8;
  localparam logic [7:0] CMD_MODE_RD = 8'hB9;
  localparam logic [7:0] CMD_HW_WR   = 8'hBA;
  localparam logic [7:0] CMD_HW_RD   = 8'hBB;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [15:0] HWCFG_RST  = 16'h2340;
  localparam logic [3:0]  CLKDIV_RST = 4'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int SUSP_DLY_US   = 2000;
  localparam int SUSP_DLY_CYC  = SUSP_DLY_US * (CLK_HZ / 1_000_000);
  localparam int IRQ_PULSE_NS  = 166;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_CLK_HZ   = 100_000;
  localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_CLK_HZ);

  // ---------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic dma_width_sel;
    logic rsv6;
    logic suspend_trigger;
    logic rsv4;
    logic irq_global_en;
    logic diag_irq_mode;
    logic rsv1;
    logic soft_attach_en;
  } usbdm_mode_t;

  typedef struct packed {
    logic       rsv15;
    logic       ext_pullup_sel;
    logic       slow_clk_disable;
    logic       clk_keep_running;
    logic [3:0] clk_out_divider;
    logic       ack_only_dma_mode;
    logic [2:0] pin_pol;
    logic       wake_on_cs;
    logic       suspend_power_off;
    logic       irq_pulse_mode;
    logic       irq_pol;
  } usbdm_hwcfg_t;

  // Host bus pins as seen by the device.
  typedef struct packed {
    logic        cs_n;
    logic        a0;
    logic        wr_n;
    logic        rd_n;
    logic [15:0] din;
  } usbdm_bus_t;

  localparam usbdm_bus_t BUS_IDLE = 20'hB_0000;

  // Transaction events from the USB engine.
  typedef struct packed {
    logic ack_bulk;
    logic iso_done;
    logic nak;
    logic err;
  } usbdm_ev_t;

  typedef enum logic [2:0] {
    SUSP_RUN  = 3'b001,
    SUSP_WAIT = 3'b010,
    SUSP_DEEP = 3'b100
  } usbdm_susp_t;

endpackage

// File: design/usbdm_clkdiv.sv
module usbdm_clkdiv #(
  parameter int                 DIV_W   = 4,
  parameter logic [DIV_W-1:0]   DIV_RST = usbdm_pkg::CLKDIV_RST
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Divider control
  input  wire logic [DIV_W-1:0] div_n,
  output logic                  clk_o
);
  import usbdm_pkg::*;

  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] nxt_cnt;
  logic [DIV_W-1:0] n_ff;
  logic [DIV_W-1:0] nxt_n;
  logic             ph_ff;
  logic             nxt_ph;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  // Each half lasts N+1 cycles; a new N is taken only at the end of
  // a high half, so no period is ever cut short.
  always_comb begin
    nxt_cnt = cnt_ff + 1'b1;
    nxt_n   = n_ff;
    nxt_ph  = ph_ff;
    if (cnt_ff == n_ff) begin // RULE17
      nxt_cnt = '0;
      nxt_ph  = ~ph_ff;
      if (ph_ff) begin
        nxt_n = div_n; // RULE19
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      n_ff   <= DIV_RST; // RULE18
      ph_ff  <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      n_ff   <= nxt_n;
      ph_ff  <= nxt_ph;
    end
  end

  assign clk_o = ph_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_div_load: assert property ((cnt_ff == n_ff && ph_ff) |=> n_ff == $past(div_n)) // RULE19
    else $error("divider not loaded at period end");
  a_div_hold: assert property (!(cnt_ff == n_ff && ph_ff) |=> $stable(n_ff)) // RULE19
    else $error("divider changed mid period");
  a_half_len: assert property ($changed(ph_ff) |-> cnt_ff == '0) // RULE17
    else $error("clock half not restarted");
  c_div_change: cover property ($changed(n_ff));

endmodule

// File: design/usbdm_cfg.sv
module usbdm_cfg #(
  parameter int SUSP_DLY_CYC_P = usbdm_pkg::SUSP_DLY_CYC
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Host command bus pins
  input  wire usbdm_pkg::usbdm_bus_t bus_pins,
  output logic [15:0]               bus_dout,
  output logic                      bus_doe_n,
  // USB engine side
  input  wire logic                 usb_bus_rst,
  input  wire logic                 usb_resume,
  input  wire usbdm_pkg::usbdm_ev_t usb_ev,
  input  wire logic                 irq_ack,
  // Interrupt pin
  output logic                      dev_irq_pin,
  // DMA and attach control
  output logic                      dma_width_16,
  output logic                      ack_only_dma_mode,
  output logic                      dp_pullup_en,
  // Suspend and clocking
  output logic                      suspended,
  output logic                      suspend_power_off,
  output logic                      osc_run,
  output logic                      clk_out_pin
);
  import usbdm_pkg::*;

  localparam int DCW = $clog2(SUSP_DLY_CYC_P + 1);
  localparam int SCW = $clog2(SLOW_HALF_CYC + 1);
  localparam int PCW = $clog2(IRQ_PULSE_CYC + 1);
  localparam logic [DCW-1:0] DLY_LAST   = DCW'(SUSP_DLY_CYC_P - 1);
  localparam logic [SCW-1:0] SLOW_LAST  = SCW'(SLOW_HALF_CYC - 1);
  localparam logic [PCW-1:0] PULSE_INIT = PCW'(IRQ_PULSE_CYC);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  usbdm_bus_t s1_ff;
  usbdm_bus_t s2_ff;
  usbdm_bus_t s3_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= BUS_IDLE;
      s2_ff <= BUS_IDLE;
      s3_ff <= BUS_IDLE;
    end else begin
      s1_ff <= bus_pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Strobes are taken on their synchronised falling edge.
  logic wr_edge;
  logic rd_edge;
  logic rd_hold;
  logic cmd_wr;
  logic data_wr;

  assign wr_edge = s3_ff.wr_n & ~s2_ff.wr_n & ~s2_ff.cs_n;
  assign rd_hold = ~s2_ff.rd_n & ~s2_ff.cs_n & ~s2_ff.a0;
  assign rd_edge = s3_ff.rd_n & rd_hold;
  assign cmd_wr  = wr_edge & s2_ff.a0;
  assign data_wr = wr_edge & ~s2_ff.a0;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]   cmd_ff;
  logic [7:0]   nxt_cmd;
  usbdm_mode_t  mode_ff;
  usbdm_mode_t  nxt_mode;
  usbdm_hwcfg_t hw_ff;
  usbdm_hwcfg_t nxt_hw;
  logic         mode_wr;
  logic         hw_wr;
  logic         go_susp;

  assign mode_wr = data_wr & (cmd_ff == CMD_MODE_WR);
  assign hw_wr   = data_wr & (cmd_ff == CMD_HW_WR); // RULE9

  always_comb begin
    nxt_cmd  = cmd_ff;
    nxt_mode = mode_ff;
    nxt_hw   = hw_ff;
    if (cmd_wr) begin
      nxt_cmd = s2_ff.din[7:0]; // RULE9
    end
    if (mode_wr) begin
      // Upper byte of the data word is ignored.
      nxt_mode = usbdm_mode_t'(s2_ff.din[7:0]);
    end else if (usb_bus_rst) begin
      // Only the trigger and reserved bits 6 and 4 are reset.
      nxt_mode.suspend_trigger = 1'b0; // RULE7
      nxt_mode.rsv6            = 1'b0;
      nxt_mode.rsv4            = 1'b0;
    end
    if (hw_wr) begin
      nxt_hw = usbdm_hwcfg_t'(s2_ff.din); // RULE10
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff  <= 8'h00;
      mode_ff <= MODE_RST;
      hw_ff   <= HWCFG_RST; // RULE18
    end else begin
      cmd_ff  <= nxt_cmd;
      mode_ff <= nxt_mode;
      hw_ff   <= nxt_hw; // RULE8
    end
  end

  // A one-then-zero write of the trigger bit starts suspend.
  assign go_susp = mode_wr & mode_ff.suspend_trigger & ~nxt_mode.suspend_trigger; // RULE2

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [15:0] dout_ff;
  logic [15:0] nxt_dout;
  logic        doe_n_ff;
  logic        nxt_doe_n;

  always_comb begin
    nxt_dout  = dout_ff;
    nxt_doe_n = ~rd_hold;
    if (rd_edge) begin
      case (cmd_ff)
        CMD_MODE_RD: nxt_dout = {8'h00, mode_ff};
        CMD_HW_RD:   nxt_dout = hw_ff; // RULE9
        default:     nxt_dout = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_ff  <= 16'h0000;
      doe_n_ff <= 1'b1;
    end else begin
      dout_ff  <= nxt_dout;
      doe_n_ff <= nxt_doe_n;
    end
  end

  assign bus_dout  = dout_ff;
  assign bus_doe_n = doe_n_ff;

  // ---------------------------------------------------------------
  // Suspend sequencer
  // ---------------------------------------------------------------
  usbdm_susp_t    st_ff;
  usbdm_susp_t    nxt_st;
  logic [DCW-1:0] dcnt_ff;
  logic [DCW-1:0] nxt_dcnt;

  always_comb begin
    nxt_st   = st_ff;
    nxt_dcnt = dcnt_ff;
    case (st_ff)
      SUSP_RUN: begin
        if (go_susp) begin
          nxt_st   = SUSP_WAIT;
          nxt_dcnt = '0;
        end
      end
      SUSP_WAIT: begin
        // Clocks stay up for the settle time after the trigger.
        if (dcnt_ff == DLY_LAST) begin // RULE13 RULE15
          nxt_st = SUSP_DEEP;
        end else begin
          nxt_dcnt = dcnt_ff + 1'b1;
        end
      end
      SUSP_DEEP: begin
        nxt_st = SUSP_DEEP;
      end
      default: begin
        nxt_st = SUSP_RUN;
      end
    endcase
    if (usb_resume | usb_bus_rst) begin
      nxt_st = SUSP_RUN;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff   <= SUSP_RUN;
      dcnt_ff <= '0;
    end else begin
      st_ff   <= nxt_st;
      dcnt_ff <= nxt_dcnt;
    end
  end

  // ---------------------------------------------------------------
  // Clock sources
  // ---------------------------------------------------------------
  logic           div_clk;
  logic [SCW-1:0] scnt_ff;
  logic [SCW-1:0] nxt_scnt;
  logic           slow_ff;
  logic           nxt_slow;

  usbdm_clkdiv #(
    .DIV_W   (4),
    .DIV_RST (CLKDIV_RST)
  ) u_clkdiv (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .div_n   (hw_ff.clk_out_divider), // RULE17
    .clk_o   (div_clk)
  );

  always_comb begin
    nxt_scnt = scnt_ff + 1'b1;
    nxt_slow = slow_ff;
    if (scnt_ff == SLOW_LAST) begin
      nxt_scnt = '0;
      nxt_slow = ~slow_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scnt_ff <= '0;
      slow_ff <= 1'b0;
    end else begin
      scnt_ff <= nxt_scnt;
      slow_ff <= nxt_slow;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt and pin outputs
  // ---------------------------------------------------------------
  logic           ev_hit;
  logic           irq_src;
  logic           flag_ff;
  logic           nxt_flag;
  logic [PCW-1:0] pcnt_ff;
  logic [PCW-1:0] nxt_pcnt;
  logic           nxt_irq;
  logic           nxt_dma16;
  logic           nxt_ackonly;
  logic           nxt_pullup;
  logic           nxt_susp;
  logic           nxt_pwr;
  logic           nxt_osc;
  logic           nxt_clk_out_pin;

  always_comb begin
    if (mode_ff.diag_irq_mode) begin
      ev_hit = usb_ev.nak | usb_ev.err; // RULE4
    end else begin
      ev_hit = usb_ev.ack_bulk | usb_ev.iso_done; // RULE5
    end
    irq_src = mode_ff.irq_global_en & ev_hit; // RULE3
    // A new event wins over an acknowledge in the same cycle.
    nxt_flag = irq_src | (flag_ff & ~irq_ack);
    if (irq_src) begin
      nxt_pcnt = PULSE_INIT; // RULE20
    end else if (pcnt_ff != '0) begin
      nxt_pcnt = pcnt_ff - 1'b1;
    end else begin
      nxt_pcnt = '0;
    end
    if (hw_ff.irq_pulse_mode) begin
      nxt_irq = mode_ff.irq_global_en & (nxt_pcnt != '0); // RULE20
    end else begin
      nxt_irq = mode_ff.irq_global_en & nxt_flag; // RULE3
    end
    nxt_dma16   = mode_ff.dma_width_sel; // RULE1
    nxt_ackonly = hw_ff.ack_only_dma_mode; // RULE21
    nxt_pullup  = mode_ff.soft_attach_en & ~hw_ff.ext_pullup_sel; // RULE6 RULE11
    nxt_susp    = (st_ff != SUSP_RUN);
    nxt_pwr     = (st_ff != SUSP_RUN) & hw_ff.suspend_power_off; // RULE22
    nxt_osc     = hw_ff.clk_keep_running | (st_ff != SUSP_DEEP); // RULE14 RULE15
    if (st_ff == SUSP_DEEP) begin
      nxt_clk_out_pin = ~hw_ff.slow_clk_disable & slow_ff; // RULE12 RULE13
    end else begin
      nxt_clk_out_pin = div_clk;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff           <= 1'b0;
      pcnt_ff           <= '0;
      dev_irq_pin       <= 1'b0;
      dma_width_16      <= 1'b0;
      ack_only_dma_mode <= 1'b0;
      dp_pullup_en      <= 1'b0;
      suspended         <= 1'b0;
      suspend_power_off <= 1'b0;
      osc_run           <= 1'b1;
      clk_out_pin       <= 1'b0;
    end else begin
      flag_ff           <= nxt_flag;
      pcnt_ff           <= nxt_pcnt;
      dev_irq_pin       <= nxt_irq;
      dma_width_16      <= nxt_dma16;
      ack_only_dma_mode <= nxt_ackonly;
      dp_pullup_en      <= nxt_pullup;
      suspended         <= nxt_susp;
      suspend_power_off <= nxt_pwr;
      osc_run           <= nxt_osc;
      clk_out_pin       <= nxt_clk_out_pin;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_dma_width: assert property ((mode_wr && s2_ff.din[7]) |-> ##2 dma_width_16) // RULE1
    else $error("DMA width not set by mode write");
  a_susp_entry: assert property ((go_susp && !usb_resume && !usb_bus_rst) |=> st_ff == SUSP_WAIT) // RULE2
    else $error("suspend not entered after trigger");
  a_irq_gate: assert property ((!mode_ff.irq_global_en && $past(!mode_ff.irq_global_en)) |-> !dev_irq_pin) // RULE3
    else $error("interrupt seen while disabled");
  a_diag_nak: assert property ((irq_src && mode_ff.diag_irq_mode && !hw_ff.irq_pulse_mode
                                && !mode_wr) |=> dev_irq_pin) // RULE4
    else $error("diagnostic event gave no interrupt");
  a_norm_ack: assert property ((mode_ff.irq_global_en && !mode_ff.diag_irq_mode && usb_ev.ack_bulk
                                && !hw_ff.irq_pulse_mode && !mode_wr) |=> dev_irq_pin) // RULE5
    else $error("bulk ACK gave no interrupt");
  a_soft_ext: assert property (hw_ff.ext_pullup_sel |=> !dp_pullup_en) // RULE6
    else $error("pull-up enabled with external resistor");
  a_busrst_keep: assert property ((usb_bus_rst && !mode_wr && !hw_wr) |=>
                                  ($stable(hw_ff) && $stable(mode_ff.dma_width_sel)
                                   && $stable(mode_ff.irq_global_en) && $stable(mode_ff.diag_irq_mode)
                                   && $stable(mode_ff.soft_attach_en))) // RULE7
    else $error("bus reset altered kept settings");
  a_pulse_len: assert property (($rose(dev_irq_pin) && hw_ff.irq_pulse_mode && mode_ff.irq_global_en
                                 && !mode_wr && !hw_wr) |-> dev_irq_pin [*4]) // RULE20
    else $error("interrupt pulse too short");
  a_slow_off: assert property ((st_ff == SUSP_DEEP && hw_ff.slow_clk_disable) |=> !clk_out_pin) // RULE12
    else $error("slow clock driven while disabled");
  a_susp_time: assert property ((st_ff == SUSP_WAIT && dcnt_ff == DLY_LAST && !usb_resume
                                 && !usb_bus_rst) |=> st_ff == SUSP_DEEP) // RULE13
    else $error("deep suspend not reached after delay");
  a_osc_keep: assert property (hw_ff.clk_keep_running |=> osc_run) // RULE14
    else $error("oscillator stopped while kept running");
  a_pwr_sw: assert property ((st_ff != SUSP_RUN && hw_ff.suspend_power_off) |=> suspend_power_off) // RULE22
    else $error("power switch not driven in suspend");

  c_go_susp: cover property (go_susp);
  c_deep: cover property (st_ff == SUSP_DEEP && !osc_run);
  c_pulse: cover property ($rose(dev_irq_pin) && hw_ff.irq_pulse_mode);
  c_hw_wr: cover property (hw_wr);

endmodule

// File: test/usbdm_host_bfm.sv
module usbdm_host_bfm (
  // Clock
  input  wire logic             ref_clk,
  // Host bus pins
  output usbdm_pkg::usbdm_bus_t bus_pins,
  input  wire logic [15:0]      bus_dout,
  input  wire logic             bus_doe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbdm_pkg::*;

  initial begin
    bus_pins = BUS_IDLE;
  end

  // One strobe: held four edges, and a read is held until the data is driven.
  task automatic strobe(input logic a0, input logic rd, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(negedge ref_clk);
    bus_pins.cs_n = 1'b0;
    bus_pins.a0   = a0;
    bus_pins.din  = d;
    bus_pins.rd_n = ~rd;
    bus_pins.wr_n = rd;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (n < 4 || (rd && bus_doe_n !== 1'b0 && n < 12));
    q = (bus_doe_n === 1'b0) ? bus_dout : 16'hxxxx;
    @(negedge ref_clk);
    // Released data lines show the inverse so stale values never look valid.
    bus_pins = '{cs_n: 1'b1, a0: 1'b1, wr_n: 1'b1, rd_n: 1'b1, din: ~d};
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic reg_write(input logic [7:0] cmd, input logic [15:0] d);
    logic [15:0] q;
    strobe(1'b1, 1'b0, {8'h00, cmd}, q);
    strobe(1'b0, 1'b0, d, q);
  endtask

  task automatic reg_read(input logic [7:0] cmd, output logic [15:0] q);
    strobe(1'b1, 1'b0, {8'h00, cmd}, q);
    strobe(1'b0, 1'b1, ~q, q);
  endtask
endmodule

// File: test/test_usb_dev_mode_hw_config.sv
module test_usb_dev_mode_hw_config;
  timeunit 1ns;
  timeprecision 1ps;
  import usbdm_pkg::*;

  localparam int SUSP_P = 20;

  logic        ref_clk;
  logic        rst_n;
  usbdm_bus_t  bus_pins;
  logic [15:0] bus_dout;
  logic        bus_doe_n;
  logic        usb_bus_rst;
  logic        usb_resume;
  usbdm_ev_t   usb_ev;
  logic        irq_ack;
  logic        dev_irq_pin;
  logic        dma_width_16;
  logic        ack_only_dma_mode;
  logic        dp_pullup_en;
  logic        suspended;
  logic        suspend_power_off;
  logic        osc_run;
  logic        clk_out_pin;
  int          error_cnt;
  int          n_compared;
  logic [15:0] q;
  logic [15:0] cfg;
  logic [7:0]  mode;
  int          hi;
  int          lo;
  int          old_half;
  logic [7:0]  tm[8] = '{8'h08, 8'h08, 8'h08, 8'h0C, 8'h0C, 8'h0C, 8'h04, 8'h01};
  logic [3:0]  te[8] = '{4'h2, 4'h8, 4'h4, 4'h2, 4'h1, 4'h8, 4'h2, 4'h8};
  logic        tx[8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  usbdm_cfg #(.SUSP_DLY_CYC_P(SUSP_P)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_pins(bus_pins), .bus_dout(bus_dout),
    .bus_doe_n(bus_doe_n), .usb_bus_rst(usb_bus_rst), .usb_resume(usb_resume),
    .usb_ev(usb_ev), .irq_ack(irq_ack), .dev_irq_pin(dev_irq_pin),
    .dma_width_16(dma_width_16), .ack_only_dma_mode(ack_only_dma_mode),
    .dp_pullup_en(dp_pullup_en), .suspended(suspended),
    .suspend_power_off(suspend_power_off), .osc_run(osc_run), .clk_out_pin(clk_out_pin)
  );

  usbdm_host_bfm host (
    .ref_clk(ref_clk), .bus_pins(bus_pins), .bus_dout(bus_dout), .bus_doe_n(bus_doe_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic int half_of(input logic [15:0] c);
    return int'(c[11:8]) + 1;
  endfunction

  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Measures one high and one low half of the clock output in cycles.
  task automatic measure(output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (clk_out_pin !== 1'b0 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    while (clk_out_pin !== 1'b1 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    while (clk_out_pin === 1'b1 && n < 600) begin
      @(negedge ref_clk);
      h++;
      n++;
    end
    while (clk_out_pin === 1'b0 && n < 600) begin
      @(negedge ref_clk);
      l++;
      n++;
    end
    if (n >= 600) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  task automatic fire(input logic [3:0] ev);
    @(negedge ref_clk);
    usb_ev = ev;
    @(negedge ref_clk);
    usb_ev = '0;
    @(negedge ref_clk);
  endtask

  task automatic pulse_resume;
    @(negedge ref_clk);
    usb_resume = 1'b1;
    @(negedge ref_clk);
    usb_resume = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask

  initial begin
    rst_n       = 1'b0;
    usb_bus_rst = 1'b0;
    usb_resume  = 1'b0;
    usb_ev      = '0;
    irq_ack     = 1'b0;
    error_cnt   = 0;
    n_compared  = 0;
    void'($urandom(32'h8aec));
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    // ---------------------------------------------------------------
    // Reset state
    // ---------------------------------------------------------------
    host.reg_read(CMD_MODE_RD, q);
    check("mode_rst", q, {8'h00, MODE_RST});
    host.reg_read(CMD_HW_RD, q);
    check("hwcfg_rst", q, HWCFG_RST);
    host.reg_read(8'hb4, q);
    check("unknown_rd", q, 16'h0000);
    measure(hi, lo);
    check("clk_hi_rst", 16'(hi), 16'(CLKDIV_RST) + 16'd1);
    check("clk_lo_rst", 16'(lo), 16'(CLKDIV_RST) + 16'd1);
    old_half = half_of(HWCFG_RST);
    // ---------------------------------------------------------------
    // Random register traffic
    // ---------------------------------------------------------------
    for (int i = 0; i < 10; i++) begin
      cfg  = 16'($urandom()) & 16'h7fff;
      mode = 8'($urandom()) & 8'h8d;
      if (i == 0)
        cfg[11:8] = 4'h0;
      if (i == 1)
        cfg[11:8] = 4'hf;
      host.reg_write(CMD_HW_WR, cfg);
      host.reg_write(CMD_MODE_WR, {8'($urandom()), mode});
      host.reg_read(CMD_MODE_RD, q);
      check("mode_rd", q, {8'h00, mode});
      host.reg_read(CMD_HW_RD, q);
      check("hwcfg_rd", q, cfg);
      check("dma16", 16'(dma_width_16), 16'(mode[7]));
      check("pullup", 16'(dp_pullup_en), 16'(mode[0] & ~cfg[14]));
      check("ackonly", 16'(ack_only_dma_mode), 16'(cfg[7]));
      check("no_susp", 16'(suspended), 16'd0);
      measure(hi, lo);
      check("no_runt", 16'(hi >= old_half && lo >= old_half || hi >= half_of(cfg) && lo >= half_of(cfg)), 16'd1);
      measure(hi, lo);
      check("clk_hi", 16'(hi), 16'(half_of(cfg)));
      check("clk_lo", 16'(lo), 16'(half_of(cfg)));
      old_half = half_of(cfg);
    end
    // ---------------------------------------------------------------
    // USB bus reset keeps settings
    // ---------------------------------------------------------------
    @(negedge ref_clk);
    usb_bus_rst = 1'b1;
    @(negedge ref_clk);
    usb_bus_rst = 1'b0;
    host.reg_read(CMD_MODE_RD, q);
    check("mode_busrst", q, {8'h00, mode});
    host.reg_read(CMD_HW_RD, q);
    check("hwcfg_busrst", q, cfg);
    // ---------------------------------------------------------------
    // Interrupt sources in level mode
    // ---------------------------------------------------------------
    host.reg_write(CMD_HW_WR, 16'h2340);
    for (int i = 0; i < 8; i++) begin
      host.reg_write(CMD_MODE_WR, {8'h00, tm[i]});
      fire(te[i]);
      check("irq", 16'(dev_irq_pin), 16'(tx[i]));
      @(negedge ref_clk);
      irq_ack = 1'b1;
      @(negedge ref_clk);
      irq_ack = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("irq_clr", 16'(dev_irq_pin), 16'd0);
    end
    // Pulse mode: a single event gives a fixed-width pulse.
    host.reg_write(CMD_HW_WR, 16'h2342);
    host.reg_write(CMD_MODE_WR, 16'h000c);
    @(negedge ref_clk);
    usb_ev = 4'h1;
    hi = 0;
    // Counts every sampled high cycle of the pulse, from the first one on.
    repeat (8) begin
      @(negedge ref_clk);
      usb_ev = '0;
      hi += int'(dev_irq_pin === 1'b1);
    end
    check("irq_pulse", 16'(hi), 16'(IRQ_PULSE_CYC));
    // ---------------------------------------------------------------
    // Suspend with slow clock and oscillator stop
    // ---------------------------------------------------------------
    host.reg_write(CMD_HW_WR, 16'h0304);
    host.reg_write(CMD_MODE_WR, 16'h0020);
    check("susp_early", 16'(suspended), 16'd0);
    host.reg_write(CMD_MODE_WR, 16'h0000);
    check("susp", 16'(suspended), 16'd1);
    check("pwr_off", 16'(suspend_power_off), 16'd1);
    check("osc_wait", 16'(osc_run), 16'd1);
    repeat (SUSP_P + 10) @(negedge ref_clk);
    check("osc_stop", 16'(osc_run), 16'd0);
    measure(hi, lo);
    check("slow_hi", 16'(hi), 16'(SLOW_HALF_CYC));
    check("slow_lo", 16'(lo), 16'(SLOW_HALF_CYC));
    pulse_resume();
    check("resumed", 16'(suspended), 16'd0);
    check("osc_back", 16'(osc_run), 16'd1);
    // Clocks kept running and slow clock disabled.
    host.reg_write(CMD_HW_WR, 16'h3300);
    host.reg_write(CMD_MODE_WR, 16'h0020);
    host.reg_write(CMD_MODE_WR, 16'h0000);
    repeat (SUSP_P + 10) @(negedge ref_clk);
    check("pwr_on", 16'(suspend_power_off), 16'd0);
    check("osc_keep", 16'(osc_run), 16'd1);
    hi = 0;
    repeat (300) begin
      @(negedge ref_clk);
      hi += int'(clk_out_pin !== 1'b0);
    end
    check("no_slow", 16'(hi), 16'd0);
    pulse_resume();
    print_verdict();
  end
endmodule
